// file: shared/tbc_pkg.sv
package tbc_pkg;
  // Register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] CNT_HI_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] MASK_OFS = 8'h10;
  // Control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CAS_BIT = 1;
  localparam int CTRL_IE_BIT = 2;
  localparam int CTRL_ARTEN_BIT = 3;
  localparam int CTRL_PSC_LSB = 4;
  // Reset values and slave-error read data
  localparam logic [2:0] PSC_RST = 3'h0;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [31:0] SLVERR_DATA = 32'h00000000;

  typedef struct packed {
    logic en;
    logic cascade_select;
    logic overflow_irq_enable;
    logic art_en;
    logic [2:0] psc;
  } tbc_ctrl_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } tbc_state_e;

  // Prescaler terminal count: standalone 2^(sel+1)-1, cascaded 2^sel-1
  function automatic logic [7:0] psc_last(input logic [2:0] sel, input logic cas);
    logic [8:0] div;
    div = cas ? (9'h001 << sel) : (9'h002 << sel);
    psc_last = 8'(div - 9'h001);
  endfunction : psc_last
endpackage : tbc_pkg

// file: hw/tbc_timer.sv
`timescale 1ns/100ps
module tbc_timer (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_IRQ,
  output tbc_pkg::tbc_ctrl_s O_CTRL
);
  import tbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  tbc_ctrl_s ctrl_r, ctrl_nxt;
  tbc_state_e state_r, state_nxt;
  logic [7:0] reload_lo_r, reload_lo_nxt;
  logic [7:0] reload_hi_r, reload_hi_nxt;
  logic [7:0] cnt_lo_r, cnt_lo_nxt;
  logic [7:0] cnt_hi_r, cnt_hi_nxt;
  logic [7:0] psc_r, psc_nxt;
  logic stat_r, stat_nxt;
  logic mask_r, mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic acc, wr, ovf, tick, lo_wrap;

  // One wait state: answer registered, pready high in second access cycle
  assign acc = I_PSEL && I_PENABLE && !pready_r;
  assign wr = acc && I_PWRITE;

  ////////////////////////////////////////////////////////////////////////////
  // Counter datapath; prescaler only advances while running
  always_comb begin
    state_nxt = state_r;
    psc_nxt = psc_r;
    cnt_lo_nxt = cnt_lo_r;
    cnt_hi_nxt = cnt_hi_r;
    tick = 1'b0;
    lo_wrap = 1'b0;
    ovf = 1'b0;
    case (state_r)
      ST_IDLE: begin
        psc_nxt = 8'h00;
        if (ctrl_r.en) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ctrl_r.en) begin
          state_nxt = ST_IDLE;
        end else begin
          // A select made smaller under a running count wraps at once, not after 256
          tick = (psc_r >= psc_last(ctrl_r.psc, ctrl_r.cascade_select));
          psc_nxt = tick ? 8'h00 : 8'(psc_r + 8'h01);
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (tick) begin
      if (ctrl_r.cascade_select) begin
        // Low stage is the reload timer, gated by its own enable
        if (ctrl_r.art_en) begin
          lo_wrap = (cnt_lo_r == 8'hFF);
          cnt_lo_nxt = lo_wrap ? reload_lo_r : 8'(cnt_lo_r + 8'h01);
          if (lo_wrap) begin
            ovf = (cnt_hi_r == 8'hFF);
            cnt_hi_nxt = ovf ? reload_hi_r : 8'(cnt_hi_r + 8'h01);
          end
        end
      end else begin
        ovf = (cnt_lo_r == 8'hFF);
        cnt_lo_nxt = ovf ? reload_lo_r : 8'(cnt_lo_r + 8'h01);
      end
    end
    // Loading a count restarts the stage from the new value
    if (wr && I_PADDR == COUNT_OFS) begin
      cnt_lo_nxt = I_PWDATA[7:0];
    end
    if (wr && I_PADDR == CNT_HI_OFS) begin
      cnt_hi_nxt = I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_r <= ST_IDLE;
      psc_r <= 8'h00;
      cnt_lo_r <= CNT_RST;
      cnt_hi_r <= CNT_RST;
    end else if (I_CE) begin
      state_r <= state_nxt;
      psc_r <= psc_nxt;
      cnt_lo_r <= cnt_lo_nxt;
      cnt_hi_r <= cnt_hi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and APB answer
  always_comb begin
    ctrl_nxt = ctrl_r;
    reload_lo_nxt = reload_lo_r;
    reload_hi_nxt = reload_hi_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    prdata_nxt = 32'h00000000;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    if (acc) begin
      if (I_PADDR == CTRL_OFS) begin
        if (I_PWRITE) begin
          ctrl_nxt.en = I_PWDATA[CTRL_EN_BIT];
          ctrl_nxt.cascade_select = I_PWDATA[CTRL_CAS_BIT];
          ctrl_nxt.overflow_irq_enable = I_PWDATA[CTRL_IE_BIT];
          ctrl_nxt.art_en = I_PWDATA[CTRL_ARTEN_BIT];
          ctrl_nxt.psc = I_PWDATA[CTRL_PSC_LSB +: 3];
        end
        prdata_nxt = {25'h0000000, ctrl_r.psc, ctrl_r.art_en,
                      ctrl_r.overflow_irq_enable, ctrl_r.cascade_select, ctrl_r.en};
      end else if (I_PADDR == COUNT_OFS) begin
        if (I_PWRITE) begin
          reload_lo_nxt = I_PWDATA[7:0];
        end
        prdata_nxt = {24'h000000, cnt_lo_r};
      end else if (I_PADDR == CNT_HI_OFS) begin
        if (I_PWRITE) begin
          reload_hi_nxt = I_PWDATA[7:0];
        end
        prdata_nxt = {24'h000000, cnt_hi_r};
      end else if (I_PADDR == STAT_OFS) begin
        if (I_PWRITE && I_PWDATA[0]) begin
          stat_nxt = 1'b0;
        end
        prdata_nxt = {31'h00000000, stat_r};
      end else if (I_PADDR == MASK_OFS) begin
        if (I_PWRITE) begin
          mask_nxt = I_PWDATA[0];
        end
        prdata_nxt = {31'h00000000, mask_r};
      end else begin
        prdata_nxt = SLVERR_DATA;
        pslverr_nxt = 1'b1; // Unmapped address
      end
    end
    // Set wins over a simultaneous clear so no overflow is lost
    if (ovf) begin
      stat_nxt = 1'b1;
    end
    // Both the enable and the mask must pass the event
    irq_nxt = stat_nxt && mask_nxt && ctrl_nxt.overflow_irq_enable;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_r <= '{en: 1'b0, cascade_select: 1'b0, overflow_irq_enable: 1'b0,
                  art_en: 1'b0, psc: PSC_RST};
      reload_lo_r <= CNT_RST;
      reload_hi_r <= CNT_RST;
      stat_r <= 1'b0;
      mask_r <= 1'b1;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (I_CE) begin
      ctrl_r <= ctrl_nxt;
      reload_lo_r <= reload_lo_nxt;
      reload_hi_r <= reload_hi_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_IRQ = irq_r;
  assign O_CTRL = ctrl_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Standalone counter at its top with the tick due on this edge
  sequence last_count_s;
    state_r == ST_RUN && ctrl_r.en && !ctrl_r.cascade_select && cnt_lo_r == 8'hFF
      && psc_r == psc_last(ctrl_r.psc, 1'b0) && I_CE;
  endsequence

  // Low stage of the chain steps on this edge
  sequence cas_tick_s;
    state_r == ST_RUN && ctrl_r.en && ctrl_r.cascade_select && ctrl_r.art_en && I_CE
      && psc_r >= psc_last(ctrl_r.psc, 1'b1);
  endsequence

  // Both stages at the top: the next tick is the chain's overflow
  sequence chain_top_s;
    cnt_lo_r == 8'hFF && cnt_hi_r == 8'hFF && !wr;
  endsequence

  // Low stage at the top while the high stage still has room: a carry
  sequence low_carry_s;
    cnt_lo_r == 8'hFF && cnt_hi_r != 8'hFF && !wr;
  endsequence

  // Reset state and reset outputs
  reset_state_a: assert property (@(posedge I_CLK) $past(I_SRST) |->
    !ctrl_r.en && !ctrl_r.cascade_select && !ctrl_r.overflow_irq_enable && ctrl_r.psc == 3'h0)
    else $error("reset configuration wrong");
  reset_out_a: assert property (@(posedge I_CLK) $past(I_SRST) |->
    !O_IRQ && !O_PREADY && mask_r && !stat_r && cnt_lo_r == CNT_RST)
    else $error("reset outputs wrong");

  // Interrupt path: enable, mask and flag must all agree
  irq_gate_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_IRQ |-> ctrl_r.overflow_irq_enable && stat_r && mask_r)
    else $error("irq without enable");
  irq_raise_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    stat_r && mask_r && ctrl_r.overflow_irq_enable |-> O_IRQ)
    else $error("irq missing while pending");

  // Sticky overflow flag: set wins, only a written one clears it
  flag_sticky_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    stat_r && !(wr && I_PADDR == STAT_OFS) |=> stat_r)
    else $error("overflow flag dropped");
  flag_set_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    ovf && I_CE |=> stat_r)
    else $error("overflow flag not set");
  flag_clear_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    wr && I_PADDR == STAT_OFS && I_PWDATA[0] && !ovf && I_CE |=> !stat_r)
    else $error("overflow flag not cleared");

  // Standalone counting and reload
  reload_wrap_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    last_count_s ##0 !(wr && I_PADDR == COUNT_OFS) |=> cnt_lo_r == $past(reload_lo_r) && stat_r)
    else $error("no reload on overflow");
  presc_range_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    state_r == ST_RUN && ctrl_r.en && !ctrl_r.cascade_select && I_CE
      |=> psc_r <= psc_last($past(ctrl_r.psc), 1'b0))
    else $error("prescaler out of range");
  lo_load_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    wr && I_PADDR == COUNT_OFS && I_CE
      |=> cnt_lo_r == 8'($past(I_PWDATA)) && reload_lo_r == 8'($past(I_PWDATA)))
    else $error("low count not loaded");

  // Cascaded chain: carry, overflow and prescaler range
  chain_wrap_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    cas_tick_s ##0 chain_top_s |=> cnt_lo_r == $past(reload_lo_r)
      && cnt_hi_r == $past(reload_hi_r) && stat_r)
    else $error("chain did not reload on overflow");
  low_carry_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    cas_tick_s ##0 low_carry_s |=> cnt_lo_r == $past(reload_lo_r)
      && cnt_hi_r == 8'($past(cnt_hi_r) + 8'h01))
    else $error("low stage wrap did not carry");
  cas_range_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    state_r == ST_RUN && ctrl_r.en && ctrl_r.cascade_select && I_CE
      |=> psc_r <= psc_last($past(ctrl_r.psc), 1'b1))
    else $error("cascaded prescaler out of range");
  hi_load_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    wr && I_PADDR == CNT_HI_OFS && I_CE
      |=> cnt_hi_r == 8'($past(I_PWDATA)) && reload_hi_r == 8'($past(I_PWDATA)))
    else $error("high count not loaded");
  art_gate_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    ctrl_r.cascade_select && !ctrl_r.art_en && !wr && I_CE |=> $stable(cnt_lo_r))
    else $error("low stage ran while off");

  // Start, stop and clock-enable freeze
  stop_freeze_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    state_r == ST_IDLE && !wr && I_CE |=> cnt_lo_r == $past(cnt_lo_r) && psc_r == 8'h00)
    else $error("counter moves while off");
  start_run_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    state_r == ST_IDLE && ctrl_r.en && I_CE |=> state_r == ST_RUN)
    else $error("enable did not start");
  hold_freeze_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    !I_CE |=> $stable(state_r) && $stable(cnt_lo_r) && $stable(cnt_hi_r) && $stable(psc_r)
      && $stable(O_PREADY) && $stable(O_IRQ))
    else $error("state moved with clock enable low");

  // Register bus answer; one wait state, so software sees a fresh count
  apb_ready_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_PSEL && !I_PENABLE ##1 I_PSEL && I_PENABLE && I_CE |=> O_PREADY)
    else $error("apb answer late");
  count_read_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    acc && !I_PWRITE && I_PADDR == COUNT_OFS && I_CE
      |=> O_PREADY && O_PRDATA == {24'h000000, $past(cnt_lo_r)})
    else $error("count read wrong");
  slverr_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    acc && I_CE && I_PADDR > MASK_OFS |=> O_PSLVERR && O_PRDATA == SLVERR_DATA)
    else $error("unmapped access not refused");
endmodule : tbc_timer

// file: tb/tbc_timer_tb.sv
`timescale 1ns/100ps
module tbc_timer_tb;
  import tbc_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (a), (b)); end end
  logic I_CLK;
  logic I_SRST;
  logic I_CE;
  logic I_PSEL;
  logic I_PENABLE;
  logic I_PWRITE;
  logic [7:0] I_PADDR;
  logic [31:0] I_PWDATA;
  logic [31:0] O_PRDATA;
  logic O_PREADY;
  logic O_PSLVERR;
  logic O_IRQ;
  tbc_ctrl_s O_CTRL;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [31:0] hold;
  logic err;
  int n;
  int dv;
  ////////////////////////////////////////////////////////////////////////////////
  tbc_timer dut_u (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_CE(I_CE), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ),
    .O_CTRL(O_CTRL));
  // Free-running 200 MHz clock
  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end
  // Single exit point for verdict and hang cut-off
  task report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    k = 0;
    // Look half a cycle after each edge, so the value is the one the next edge sees
    do begin
      @(negedge I_CLK);
      k++;
    end while (O_PREADY !== 1'b1 && k < 20);
    if (k >= 20) begin
      miscompares++;
      report_and_stop;
    end
    rd = O_PRDATA;
    err = O_PSLVERR;
    @(posedge I_CLK);
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask : apb
  // Cycles until the interrupt line rises, bounded so a dead timer cannot hang
  task wait_irq(output int c);
    c = 0;
    do begin
      @(negedge I_CLK);
      c++;
      if (c > 9000) begin
        miscompares++;
        report_and_stop;
      end
    end while (O_IRQ !== 1'b1);
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////////////
  // Clock enable stays high except in the cascade test, which holds it low for 100 cycles to check the freeze
  initial begin
    I_SRST = 1'b1;
    I_CE = 1'b1;
    I_PSEL = 1'b0;
    I_PENABLE = 1'b0;
    I_PWRITE = 1'b0;
    I_PADDR = 8'h00;
    I_PWDATA = 32'h00000000;
    repeat (16) @(posedge I_CLK);
    I_SRST <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, 32'h00000000)
    `CHK(O_CTRL, 7'h00)
    apb(1'b0, MASK_OFS, 32'h0);
    `CHK(rd, 32'h00000001)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    // Every prescale code in both modes; start F0 gives sixteen ticks
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 8; s++) begin
        dv = (c != 0 ? 1 : 2) << s;
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, STAT_OFS, 32'h1);
        apb(1'b1, COUNT_OFS, 32'hF0);
        apb(1'b1, CNT_HI_OFS, 32'hFF);
        apb(1'b1, CTRL_OFS, {25'h0, 3'(s), (c != 0 ? 4'hF : 4'h5)});
        wait_irq(n);
        `CHK(n > 16 * dv - 4 && n < 16 * dv + 6, 1'b1)
        `CHK({O_CTRL.cascade_select, O_CTRL.psc}, {c[0], 3'(s)})
      end
    end
    // First wait returns on the flag left set by the loop; the second times the first overflow from the F0 load
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, COUNT_OFS, 32'hF0);
    apb(1'b1, CTRL_OFS, 32'h5);
    wait_irq(n);
    apb(1'b1, STAT_OFS, 32'h1);
    wait_irq(n);
    `CHK(n >= 20 && n <= 36, 1'b1)
    // Stopped timer holds count and raises nothing
    apb(1'b1, CTRL_OFS, 32'h4);
    apb(1'b1, STAT_OFS, 32'h1);
    apb(1'b0, COUNT_OFS, 32'h0);
    hold = rd;
    repeat (40) @(posedge I_CLK);
    apb(1'b0, COUNT_OFS, 32'h0);
    `CHK(rd, hold)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b1, COUNT_OFS, 32'hA5);
    apb(1'b0, COUNT_OFS, 32'h0);
    `CHK(rd, 32'h000000A5)
    // Overflow without enable: flag only, then enable, mask and clear
    apb(1'b1, COUNT_OFS, 32'hF0);
    apb(1'b1, CTRL_OFS, 32'h1);
    repeat (60) @(posedge I_CLK);
    `CHK(O_IRQ, 1'b0)
    apb(1'b1, CTRL_OFS, 32'h4);
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rd, 32'h00000001)
    `CHK(O_IRQ, 1'b1)
    apb(1'b1, MASK_OFS, 32'h0);
    repeat (2) @(posedge I_CLK);
    `CHK(O_IRQ, 1'b0)
    apb(1'b1, MASK_OFS, 32'h1);
    apb(1'b1, STAT_OFS, 32'h1);
    repeat (2) @(posedge I_CLK);
    `CHK(O_IRQ, 1'b0)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rd, 32'h00000000)
    // Cascade with a carry; clock enable low freezes the chain meanwhile
    apb(1'b1, COUNT_OFS, 32'hF0);
    apb(1'b1, CNT_HI_OFS, 32'hFE);
    apb(1'b1, CTRL_OFS, 32'hF);
    I_CE <= 1'b0;
    repeat (100) @(posedge I_CLK);
    `CHK(O_IRQ, 1'b0)
    I_CE <= 1'b1;
    wait_irq(n);
    `CHK(n > 20 && n < 40, 1'b1)
    report_and_stop;
  end
endmodule : tbc_timer_tb
